// [pkg/acc_pkg.sv]
// constants and types of the adc calibration correction path
// Overview of operation
// RULE1: bipolar zero gives 0x800000 or 0x000000; out-of-range results clamp to format limits.
// RULE2: system offset coefficient is 24 bits, host read/write, bit 23 most significant.
// RULE3: all four coefficients are signed two's complement values.
// RULE4: system coefficients hold until host rewrite or system calibration result.
// RULE5: self coefficients hold until host rewrite or self calibration result.
// RULE6: system offset subtracted only while its disable bit is 0.
// RULE7: system offset after self corrections, before system gain and 1x/2x scale.
// RULE8: system gain multiplies only while its disable bit is 0.
// RULE9: system gain scales up to 2x.
// RULE10: each gain stage result within 2 LSB of ideal.
// RULE11: self offset subtracted first while its disable bit is 0.
// RULE12: self offset applied before unipolar 2x scaling.
// RULE13: self gain scales before both system corrections while its disable bit is 0.
// RULE14: self gain scales up to 2x.
// RULE15: host writes to self gain coefficient ignored during calibration.
// RULE16: bipolar format bit 0 two's complement, 1 offset binary; unipolar straight binary.
// RULE17: a disabled stage passes its input unchanged.
package acc_pkg;
    localparam int COEF_W    = 24;
    localparam int INT_W     = 28;
    localparam int GAIN_FRAC = 23;
    localparam int ADDR_W    = 8;

    localparam logic [COEF_W-1:0] COEF_RST     = 24'h00_0000;
    localparam logic [COEF_W-1:0] CODE_MAX_UNI = 24'hFF_FFFF;
    localparam logic [COEF_W-1:0] CODE_MAX_BIP = 24'h7F_FFFF;
    localparam logic [COEF_W-1:0] CODE_MSB     = 24'h80_0000;

    // register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_COEF_LAST = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_CTRL      = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_CAL       = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_DATA      = 8'h18;
    localparam logic [ADDR_W-1:0] ADDR_STAT      = 8'h1C;
    localparam int COEF_IDX_LSB = 2;

    // control register fields
    localparam int CTRL_SELF_OFS_DIS  = 1;
    localparam int CTRL_SELF_GAIN_DIS = 2;
    localparam int CTRL_SYS_OFS_DIS   = 3;
    localparam int CTRL_SYS_GAIN_DIS  = 4;
    localparam int CTRL_UNIPOLAR      = 8;
    localparam int CTRL_FORMAT        = 9;
    localparam logic [31:0] CTRL_RST  = 32'h0000_001E;
    localparam logic [31:0] CTRL_MASK = 32'h0000_031E;

    // calibration and status fields
    localparam int CAL_KIND_LSB = 0;
    localparam int CAL_START    = 2;
    localparam int STAT_READY   = 0;
    localparam int STAT_BUSY    = 1;

    // coefficient index doubles as calibration kind
    typedef enum logic [1:0] {
        ACC_SELF_OFS  = 2'h0,
        ACC_SELF_GAIN = 2'h1,
        ACC_SYS_OFS   = 2'h2,
        ACC_SYS_GAIN  = 2'h3
    } acc_kind_t;

    typedef enum logic [1:0] {
        ACC_CAL_IDLE = 2'h0,
        ACC_CAL_RUN  = 2'h1
    } acc_cal_state_t;
endpackage

// [hw/acc_gain_stage.sv]
// one gain correction stage: y = x * (1 + coef / 2^23), rounded
`timescale 1ns/1ps
module acc_gain_stage #(
    parameter int W = acc_pkg::INT_W
) (
    // clocking
    input  wire logic                         clock,
    input  wire logic                         rst_n,
    input  wire logic                         ce,
    // stage control
    input  wire logic                         bypass,
    input  wire logic [acc_pkg::COEF_W-1:0]   coef,
    // sample in
    input  wire logic                         in_valid,
    input  wire logic signed [W-1:0]          x,
    // sample out
    output logic                              out_valid,
    output logic signed [W-1:0]               y
);
    import acc_pkg::*;

    localparam int PW = W + COEF_W;
    localparam logic signed [PW-1:0] ROUND = PW'(1) <<< (GAIN_FRAC - 1);

    initial begin
        if (W < COEF_W + 3) $error("gain stage width too small for headroom");
    end

    logic signed [PW-1:0] prod;
    logic signed [W-1:0]  scaled;

    // coef spans [-1,1), so gain spans [0,2): up to 2x, correcting -50%
    always_comb begin
        prod   = x * $signed(coef); // RULE3 RULE9 RULE14
        scaled = W'((prod + ROUND) >>> GAIN_FRAC); // RULE10
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
            y         <= '0;
        end else if (ce) begin
            out_valid <= in_valid;
            // headroom of W bits keeps the sum exact
            y <= bypass ? x : x + scaled; // RULE17
        end
    end
endmodule

// [hw/acc_formatter.sv]
// output coding: unipolar 2x scale, clamping and code format
`timescale 1ns/1ps
module acc_formatter #(
    parameter int W = acc_pkg::INT_W
) (
    // clocking
    input  wire logic                         clock,
    input  wire logic                         rst_n,
    input  wire logic                         ce,
    // mode
    input  wire logic                         unipolar,
    input  wire logic                         offset_bin,
    // corrected sample
    input  wire logic                         in_valid,
    input  wire logic signed [W-1:0]          x,
    // coded result
    output logic                              out_valid,
    output logic [acc_pkg::COEF_W-1:0]        code
);
    import acc_pkg::*;

    localparam logic signed [W-1:0] UNI_HI = W'(CODE_MAX_UNI);
    localparam logic signed [W-1:0] BIP_HI = W'(CODE_MAX_BIP);
    localparam logic signed [W-1:0] BIP_LO = ~BIP_HI;

    initial begin
        if (W < COEF_W + 2) $error("formatter width too small");
    end

    logic signed [W:0]    scaled;
    logic signed [W:0]    lo;
    logic signed [W:0]    hi;
    logic [COEF_W-1:0]    clamped;
    logic [COEF_W-1:0]    code_nxt;

    always_comb begin
        // one extra bit so doubling a large negative value cannot wrap positive
        scaled = unipolar ? {x, 1'b0} : {x[W-1], x}; // RULE12 RULE7
        lo     = unipolar ? '0 : (W+1)'(BIP_LO);
        hi     = unipolar ? (W+1)'(UNI_HI) : (W+1)'(BIP_HI);
        if (scaled < lo) begin
            clamped = lo[COEF_W-1:0]; // RULE1
        end else if (scaled > hi) begin
            clamped = hi[COEF_W-1:0]; // RULE1
        end else begin
            clamped = scaled[COEF_W-1:0];
        end
        // unipolar is always straight binary, format bit only acts in bipolar
        code_nxt = (!unipolar && offset_bin) ? clamped ^ CODE_MSB : clamped; // RULE16 RULE1
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
            code      <= '0;
        end else if (ce) begin
            out_valid <= in_valid;
            if (in_valid) begin
                code <= code_nxt;
            end
        end
    end
endmodule

// [hw/acc_correction_top.sv]
// correction path top: apb registers, calibration loading, five stages
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module acc_correction_top #(
    parameter int IW = acc_pkg::INT_W
) (
    // clocking
    input  wire logic                         clock,
    input  wire logic                         rst_n,
    input  wire logic                         ce,
    // apb slave
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [acc_pkg::ADDR_W-1:0]   paddr,
    input  wire logic [31:0]                  pwdata,
    output logic [31:0]                       prdata,
    output logic                              pready,
    output logic                              pslverr,
    // raw conversion results from the filter
    input  wire logic                         raw_valid,
    input  wire logic [acc_pkg::COEF_W-1:0]   raw_data,
    // calibration sequencer
    output logic                              cal_busy,
    output logic [1:0]                        cal_kind,
    input  wire logic                         cal_done,
    input  wire logic [acc_pkg::COEF_W-1:0]   cal_value,
    // corrected results
    output logic                              result_valid,
    output logic [acc_pkg::COEF_W-1:0]        result_data
);
    import acc_pkg::*;

    initial begin
        if (IW < COEF_W + 4) $error("internal width lacks headroom for two 2x stages");
    end

    localparam int NCOEF = 4;

    // register file
    logic [COEF_W-1:0]  coef_r [NCOEF];
    logic [31:0]        ctrl_r;
    logic [COEF_W-1:0]  data_r;
    logic               ready_r;
    acc_cal_state_t     cal_state_r;
    acc_kind_t          kind_r;

    // apb state
    logic               rdy_r;
    logic               err_r;
    logic [31:0]        prdata_r;
    logic [31:0]        rd_mux;
    logic               rd_err;
    logic               xfer;
    logic               wr;
    logic               rd;
    logic               coef_sel;
    logic [1:0]         coef_idx;

    // datapath
    logic signed [IW-1:0] s1_r;
    logic                 s1_v_r;
    logic signed [IW-1:0] s2;
    logic                 s2_v;
    logic signed [IW-1:0] s3_r;
    logic                 s3_v_r;
    logic signed [IW-1:0] s4;
    logic                 s4_v;
    logic                 fmt_v;
    logic [COEF_W-1:0]    fmt_code;

    function automatic logic signed [IW-1:0] sext(input logic [COEF_W-1:0] v);
        sext = {{(IW - COEF_W){v[COEF_W-1]}}, v}; // RULE3
    endfunction

    // ---------------- apb slave ----------------
    // read data is captured in the setup cycle so prdata is a flop
    assign pready   = ce & rdy_r;
    assign pslverr  = pready & err_r;
    assign prdata   = prdata_r;
    assign xfer     = psel & penable & pready;
    assign wr       = xfer & pwrite & ~err_r;
    assign rd       = xfer & ~pwrite & ~err_r;
    assign coef_sel = paddr <= ADDR_COEF_LAST && paddr[1:0] == 2'h0;
    assign coef_idx = paddr[COEF_IDX_LSB +: 2];

    always_comb begin
        rd_mux = '0;
        rd_err = 1'b0;
        if (coef_sel) begin
            rd_mux[COEF_W-1:0] = coef_r[coef_idx]; // RULE2
        end else begin
            case (paddr)
                ADDR_CTRL: rd_mux = ctrl_r;
                ADDR_CAL: begin
                    rd_mux[CAL_KIND_LSB +: 2] = kind_r;
                    rd_mux[CAL_START]         = cal_state_r == ACC_CAL_RUN;
                end
                ADDR_DATA: rd_mux[COEF_W-1:0] = data_r;
                ADDR_STAT: begin
                    rd_mux[STAT_READY] = ready_r;
                    rd_mux[STAT_BUSY]  = cal_state_r == ACC_CAL_RUN;
                end
                default: rd_err = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rdy_r    <= 1'b0;
            err_r    <= 1'b0;
            prdata_r <= '0;
        end else if (ce) begin
            // keyed on the idle flop so a setup seen while ce was low is still taken
            if (psel && !rdy_r) begin
                rdy_r    <= 1'b1;
                err_r    <= rd_err;
                prdata_r <= pwrite ? '0 : rd_mux;
            end else if (xfer) begin
                rdy_r <= 1'b0;
                err_r <= 1'b0;
            end
        end
    end

    // ---------------- coefficient registers ----------------
    // a calibration result lands over a host write in the same cycle
    for (genvar i = 0; i < NCOEF; i++) begin : g_coef
        logic host_we;
        logic cal_we;
        // self gain is locked against host writes while calibrating
        assign host_we = wr && coef_sel && coef_idx == 2'(i)
                         && !(i == int'(ACC_SELF_GAIN) && cal_state_r == ACC_CAL_RUN); // RULE15
        assign cal_we  = cal_done && cal_state_r == ACC_CAL_RUN && kind_r == acc_kind_t'(i);

        always_ff @(posedge clock) begin
            if (!rst_n) begin
                coef_r[i] <= COEF_RST;
            end else if (ce) begin
                if (cal_we) begin
                    coef_r[i] <= cal_value; // RULE4 RULE5
                end else if (host_we) begin
                    coef_r[i] <= pwdata[COEF_W-1:0]; // RULE2 RULE4 RULE5
                end
            end
        end
    end

    // ---------------- control register ----------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ctrl_r <= CTRL_RST;
        end else if (ce && wr && paddr == ADDR_CTRL) begin
            ctrl_r <= pwdata & CTRL_MASK;
        end
    end

    // ---------------- calibration sequencing ----------------
    // the sequencer measures and returns the coefficient for kind_r
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cal_state_r <= ACC_CAL_IDLE;
            kind_r      <= ACC_SELF_OFS;
        end else if (ce) begin
            case (cal_state_r)
                ACC_CAL_IDLE: begin
                    if (wr && paddr == ADDR_CAL && pwdata[CAL_START]) begin
                        kind_r      <= acc_kind_t'(pwdata[CAL_KIND_LSB +: 2]);
                        cal_state_r <= ACC_CAL_RUN;
                    end
                end
                ACC_CAL_RUN: begin
                    if (cal_done) begin
                        cal_state_r <= ACC_CAL_IDLE;
                    end
                end
                default: cal_state_r <= ACC_CAL_IDLE;
            endcase
        end
    end

    assign cal_busy = cal_state_r == ACC_CAL_RUN;
    assign cal_kind = kind_r;

    // ---------------- correction pipeline ----------------
    // stage 1: self offset goes first, ahead of everything else
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s1_v_r <= 1'b0;
            s1_r   <= '0;
        end else if (ce) begin
            s1_v_r <= raw_valid;
            if (raw_valid) begin
                if (ctrl_r[CTRL_SELF_OFS_DIS]) begin
                    s1_r <= sext(raw_data); // RULE17
                end else begin
                    s1_r <= sext(raw_data) - sext(coef_r[ACC_SELF_OFS]); // RULE11 RULE12
                end
            end
        end
    end

    // stage 2: self gain, before either system correction
    acc_gain_stage #(
        .W (IW)
    ) u_self_gain (
        .clock     (clock),
        .rst_n     (rst_n),
        .ce        (ce),
        .bypass    (ctrl_r[CTRL_SELF_GAIN_DIS]),
        .coef      (coef_r[ACC_SELF_GAIN]),
        .in_valid  (s1_v_r),
        .x         (s1_r),
        .out_valid (s2_v),
        .y         (s2)
    ); // RULE13 RULE14

    // stage 3: system offset, after self corrections, before system gain
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s3_v_r <= 1'b0;
            s3_r   <= '0;
        end else if (ce) begin
            s3_v_r <= s2_v;
            if (s2_v) begin
                if (ctrl_r[CTRL_SYS_OFS_DIS]) begin
                    s3_r <= s2; // RULE17
                end else begin
                    s3_r <= s2 - sext(coef_r[ACC_SYS_OFS]); // RULE6 RULE7
                end
            end
        end
    end

    // stage 4: system gain
    acc_gain_stage #(
        .W (IW)
    ) u_sys_gain (
        .clock     (clock),
        .rst_n     (rst_n),
        .ce        (ce),
        .bypass    (ctrl_r[CTRL_SYS_GAIN_DIS]),
        .coef      (coef_r[ACC_SYS_GAIN]),
        .in_valid  (s3_v_r),
        .x         (s3_r),
        .out_valid (s4_v),
        .y         (s4)
    ); // RULE8 RULE9

    // stage 5: mode scaling, clamp and code format last of all
    acc_formatter #(
        .W (IW)
    ) u_fmt (
        .clock      (clock),
        .rst_n      (rst_n),
        .ce         (ce),
        .unipolar   (ctrl_r[CTRL_UNIPOLAR]),
        .offset_bin (ctrl_r[CTRL_FORMAT]),
        .in_valid   (s4_v),
        .x          (s4),
        .out_valid  (fmt_v),
        .code       (fmt_code)
    ); // RULE7 RULE16

    assign result_valid = fmt_v;
    assign result_data  = fmt_code;

    // data register and ready flag; a new result beats a clearing read
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            data_r  <= '0;
            ready_r <= 1'b0;
        end else if (ce) begin
            if (fmt_v) begin
                data_r  <= fmt_code;
                ready_r <= 1'b1;
            end else if (rd && paddr == ADDR_DATA) begin
                ready_r <= 1'b0;
            end
        end
    end
endmodule

// [verification/acc_sva.sv]
// port checker of the correction path, bound into its top
`timescale 1ns/1ps
module acc_sva #(
    parameter int IW = 28
) (
    // clocking
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        ce,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // samples
    input wire logic        raw_valid,
    input wire logic [23:0] raw_data,
    input wire logic        result_valid,
    input wire logic [23:0] result_data,
    // calibration
    input wire logic        cal_busy,
    input wire logic [1:0]  cal_kind,
    input wire logic        cal_done,
    input wire logic [23:0] cal_value
);
    import acc_pkg::*;
    logic [1:0] kind_r;
    // kind offered with a start, kept for the check one edge later
    always_ff @(posedge clock) kind_r <= pwdata[1:0];
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_apb_answer: assert property (psel && !penable && ce |=> pready)
        else $error("no ready after setup");
    a_ready_access: assert property (pready |-> psel && penable && ce)
        else $error("ready outside an access");
    a_err_unmapped: assert property (pready && paddr > ADDR_STAT |-> pslverr && prdata == '0)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (pready && paddr <= ADDR_STAT && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped access refused");
    a_result_delay: assert property ((raw_valid && ce) ##1 ce [*4] |=> result_valid)
        else $error("result not five cycles after sample");
    a_result_hold: assert property (!result_valid |-> $stable(result_data))
        else $error("result changed without valid");
    a_cal_start: assert property (psel && penable && pready && pwrite && paddr == ADDR_CAL
        && pwdata[CAL_START] && !cal_busy |=> cal_busy && cal_kind == kind_r)
        else $error("calibration start not taken");
    a_cal_finish: assert property (cal_busy && cal_done && ce |=> !cal_busy)
        else $error("busy stays after done");
    a_cal_hold: assert property (cal_busy && !(cal_done && ce) |=> cal_busy && $stable(cal_kind))
        else $error("calibration dropped early");
endmodule

bind acc_correction_top acc_sva #(.IW(IW)) u_sva (.*);

// [verification/acc_cal_seq.sv]
// calibration sequencer model answering the correction path
`timescale 1ns/1ps
module acc_cal_seq (
    // clocking
    input  wire logic        clock,
    input  wire logic        rst_n,
    // handshake
    input  wire logic        cal_busy,
    input  wire logic [4:0]  dly,
    input  wire logic [23:0] meas,
    output logic             cal_done,
    output logic [23:0]      cal_value
);
    import acc_pkg::*;
    logic [4:0] cnt_r;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cnt_r <= 5'h00;
            cal_done <= 1'b0;
        end else if (cal_busy && !cal_done && cnt_r == dly) begin
            cal_done <= 1'b1;
            cnt_r <= 5'h00;
        end else begin
            cal_done <= 1'b0;
            cnt_r <= (cal_busy && !cal_done) ? cnt_r + 5'h01 : 5'h00;
        end
    end
    // idle line shows the inverse so a stale sample is caught
    assign cal_value = cal_done ? meas : ~meas;
endmodule

// [verification/tb_top.sv]
// self-checking bench of the correction path
`timescale 1ns/1ps
module tb_top;
    import acc_pkg::*;
    logic clock, rst_n, ce, psel, penable, pwrite, pready, pslverr;
    logic raw_valid, cal_busy, cal_done, result_valid, e, v, c;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, q, r, ctl, seed;
    logic [1:0] cal_kind;
    logic [4:0] dly;
    logic [COEF_W-1:0] raw_data, cal_value, result_data, meas, din, last;
    logic [COEF_W-1:0] cf [4];
    logic [COEF_W-1:0] expq [$];
    int n_errors = 0, total_checks = 0, cyc = 0, n;

    acc_correction_top #(.IW(INT_W)) uut (.*);
    acc_cal_seq u_seq (.*);

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // stage order and half-up rounding as agreed for the gain stages
    function automatic logic [COEF_W-1:0] model(logic [COEF_W-1:0] raw);
        longint x, g;
        x = longint'(signed'(raw));
        for (int k = 0; k < 4; k++) begin
            g = longint'(signed'(cf[k]));
            if (!ctl[k + 1]) x = k[0] ? x + ((x * g + longint'(32'h0040_0000)) >>> 23) : x - g;
        end
        if (ctl[CTRL_UNIPOLAR]) begin
            x = 2 * x;
            if (x < 0) x = 0;
            if (x > longint'(CODE_MAX_UNI)) x = longint'(CODE_MAX_UNI);
            return x[23:0];
        end
        if (x > longint'(CODE_MAX_BIP)) x = longint'(CODE_MAX_BIP);
        if (x < -longint'(CODE_MSB)) x = -longint'(CODE_MSB);
        return {x[23] ^ ctl[CTRL_FORMAT], x[22:0]};
    endfunction

    task automatic chk_reg(logic [31:0] g, logic [31:0] x);
        total_checks++;
        if (g !== x) begin
            n_errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, g, x);
        end
    endtask

    task automatic chk_res(logic [COEF_W-1:0] g, logic [COEF_W-1:0] x);
        chk_reg({8'h00, g}, {8'h00, x});
    endtask

    task automatic results();
        if (n_errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // one idle cycle after each transfer keeps psel single-driven per step
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] rd,
                       output logic er);
        int t = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1 && t < 20) begin
            @(posedge clock);
            t++;
        end
        if (t == 20) n_errors++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    always @(posedge clock) begin
        cyc++;
        // a result frozen by a low ce is counted once
        if (rst_n === 1'b1 && result_valid === 1'b1 && ce === 1'b1) begin
            chk_res(result_data, expq.size() ? expq.pop_front() : ~result_data);
        end
        if (cyc == 20000) begin
            n_errors++;
            results();
        end
    end

    initial begin
        {rst_n, psel, penable, pwrite, raw_valid} = 5'h00;
        ce = 1'b1;
        {paddr, pwdata, raw_data, meas, dly} = '0;
        seed = 32'h0000_7B78;
        ctl = CTRL_RST;
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        for (int a = 0; a < 8; a++) begin
            apb(1'b0, 8'(a * 4), '0, q, e);
            chk_reg(q, (a == 4) ? CTRL_RST : '0);
        end
        apb(1'b0, 8'h20, '0, q, e);
        chk_reg({q[30:0], e}, 32'h0000_0001);
        for (int i = 0; i < 12; i++) begin
            r = xs();
            ctl = {22'h0, i[0], i[1], 3'h0, (i < 4) ? 4'h0 : r[3:0], 1'b0};
            apb(1'b1, ADDR_CTRL, ctl, q, e);
            for (int k = 0; k < 4; k++) begin
                r = xs();
                cf[k] = (i < 2) ? '0 : r[23:0];
                apb(1'b1, 8'(k * 4), {8'h00, cf[k]}, q, e);
                apb(1'b0, 8'(k * 4), '0, q, e);
                chk_reg(q, {8'h00, cf[k]});
            end
            for (int j = 0; j < 40; j++) begin
                r = xs();
                v = (j < 3) | r[0];
                c = (j < 3) | (i < 8) | ~(r[2] & r[3]);
                din = (j == 0) ? '0 : (j == 1) ? CODE_MAX_BIP : (j == 2) ? CODE_MSB : r[31:8];
                raw_valid <= v;
                raw_data <= din;
                ce <= c;
                if (v && c) begin
                    last = model(din);
                    expq.push_back(last);
                end
                @(posedge clock);
            end
            raw_valid <= 1'b0;
            ce <= 1'b1;
            repeat (8) @(posedge clock);
            apb(1'b0, ADDR_STAT, '0, q, e);
            chk_reg(q, 32'h0000_0001);
            apb(1'b0, ADDR_DATA, '0, q, e);
            chk_reg(q, {8'h00, last});
        end
        for (int k = 0; k < 4; k++) begin
            r = xs();
            meas <= r[23:0];
            dly <= (k[0] ^ k[1]) ? 5'h01 : 5'h14;
            apb(1'b1, ADDR_CAL, 32'h0000_0004 | 32'(k), q, e);
            apb(1'b0, ADDR_CAL, '0, q, e);
            if (dly == 5'h14) begin
                chk_reg(q, 32'h0000_0004 | 32'(k));
                apb(1'b1, 8'h04, 32'h0012_3456, q, e);
                apb(1'b1, ADDR_CAL, 32'h0000_0004 | 32'(k ^ 1), q, e);
                apb(1'b0, ADDR_CAL, '0, q, e);
                chk_reg(q, 32'h0000_0004 | 32'(k));
            end
            n = 0;
            while (cal_busy !== 1'b0 && n < 50) begin
                @(posedge clock);
                n++;
            end
            if (n == 50) n_errors++;
            cf[k] = r[23:0];
            apb(1'b0, 8'(k * 4), '0, q, e);
            chk_reg(q, {8'h00, cf[k]});
            apb(1'b0, 8'h04, '0, q, e);
            chk_reg(q, {8'h00, cf[1]});
        end
        chk_reg(32'(expq.size()), '0);
        results();
    end
endmodule
